/* File: design/pwc_counter.sv */
/*
 Periodic wakeup counter: source selection, 8-bit up-counter with
 modulo compare, match flag, interrupt request and Wishbone slave.
 Assumes source clocks and debug halt are asynchronous pins,
 and a classic Wishbone master on clk.
*/
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// - Writing one to match flag clears it and its request; zero leaves it.
// - Flag sets when count passes from the limit back to zero.
// - Source 00 low-power oscillator, 01 external reference, 1x internal reference.
// - Writing a different source clears prescaler and counter.
// - Writing a different divider code clears prescaler and counter.
// - Interrupt request follows the flag while the enable is one.
// - Low source bit zero: codes 1-7 and 8-15 take the binary/decimal table.
// - Low source bit one: codes 1-7 are 2^10..2^16, 8-15 decimal thousands.
// - Divider code zero holds the prescaler off; counter does not advance.
// - Count register reads the counter and ignores writes.
// - Any limit write stores it and clears prescaler and counter.
// - With limit zero the flag sets on every prescaler pulse.
// - Counter steps once per prescaler period up to the limit, then wraps.
// - Reset stops the counter at zero with all control fields cleared.
// - Debug halt freezes counting; resumes from held value unless restarted.
module pwc_counter (
   input wire logic clk,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [pwc_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic low_power_osc_clk,
   input wire logic external_ref_clk,
   input wire logic internal_ref_clk,
   input wire logic debug_halt,
   output logic match_irq
);
   ////////////////////////////////////////////////////////////////
   // Pin synchronizers and source edge detect
   logic [pwc_pkg::SYNC_W-1:0] s1_q, s2_q;
   logic src_prev_q, src_prev_d;
   logic src_now, tick, dbg;
   logic swap_q, swap_d;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s1_q <= 4'h0;
         s2_q <= 4'h0;
         src_prev_q <= 1'b0;
      end else begin
         s1_q <= {debug_halt, internal_ref_clk, external_ref_clk, low_power_osc_clk};
         s2_q <= s1_q;
         src_prev_q <= src_prev_d;
      end
   end

   logic flag_q, flag_d;
   logic [1:0] src_q, src_d;
   logic ie_q, ie_d;
   logic [3:0] div_q, div_d;
   logic [7:0] limit_q, limit_d;
   logic [7:0] cnt_q, cnt_d;
   logic irq_q, irq_d;

   always_comb begin
      if (src_q[1]) begin
         src_now = s2_q[2];
      end else if (src_q[0]) begin
         src_now = s2_q[1];
      end else begin
         src_now = s2_q[0];
      end
      src_prev_d = src_now;
      // Old pin level is stale just after a source swap
      tick = src_now && !src_prev_q && !swap_q;
      dbg = s2_q[pwc_pkg::DBG_IDX];
   end

   ////////////////////////////////////////////////////////////////
   // Wishbone request decode
   logic ack_q, ack_d;
   logic [31:0] dat_q, dat_d;
   logic req, wr, rd, wr_ctrl, wr_limit, rd_ctrl, rd_count, rd_limit;
   logic [7:0] wdat;

   always_comb begin
      req = wb_cyc_i && wb_stb_i && !ack_q;
      wr = req && wb_we_i && wb_sel_i[0];
      rd = req && !wb_we_i;
      wdat = wb_dat_i[7:0];
      wr_ctrl = 1'b0;
      wr_limit = 1'b0;
      rd_ctrl = 1'b0;
      rd_count = 1'b0;
      rd_limit = 1'b0;
      if (wb_adr_i == pwc_pkg::OFS_CTRL) begin
         wr_ctrl = wr;
         rd_ctrl = rd;
      end else if (wb_adr_i == pwc_pkg::OFS_COUNT) begin
         rd_count = rd;
      end else if (wb_adr_i == pwc_pkg::OFS_LIMIT) begin
         wr_limit = wr;
         rd_limit = rd;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Control, counter and flag
   logic restart, src_chg, div_chg, pre_pulse, step, hit;
   logic pend_q, pend_d;

   always_comb begin
      src_chg = wr_ctrl && wdat[pwc_pkg::SRC_HI:pwc_pkg::SRC_LO] != src_q;
      div_chg = wr_ctrl && wdat[pwc_pkg::DIV_HI:0] != div_q;
      // restart on source or divider change, or on any limit write
      restart = src_chg || div_chg || wr_limit;
      // no step while debug halt is seen
      step = (pre_pulse || pend_q) && !dbg && !restart;
      // Pulse that meets the halt waits for its end
      pend_d = (pend_q || pre_pulse) && dbg && !restart;
      swap_d = src_chg;
      hit = step && cnt_q == limit_q;
      src_d = src_q;
      ie_d = ie_q;
      div_d = div_q;
      limit_d = limit_q;
      cnt_d = cnt_q;
      flag_d = flag_q;
      if (wr_ctrl) begin
         src_d = wdat[pwc_pkg::SRC_HI:pwc_pkg::SRC_LO];
         ie_d = wdat[pwc_pkg::IE_BIT];
         div_d = wdat[pwc_pkg::DIV_HI:0];
         if (wdat[pwc_pkg::FLAG_BIT]) begin
            flag_d = 1'b0;
         end
      end
      if (wr_limit) begin
         limit_d = wdat;
      end
      if (restart) begin
         cnt_d = pwc_pkg::COUNT_RST;
      end else if (hit) begin
         // wrap to zero at the limit
         cnt_d = pwc_pkg::COUNT_RST;
      end else if (step) begin
         cnt_d = cnt_q + 8'h01;
      end
      // Set wins over a same-cycle clear
      if (hit) begin
         flag_d = 1'b1;
      end
      irq_d = flag_d && ie_d;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         flag_q <= 1'b0;
         src_q <= pwc_pkg::SRC_RST;
         ie_q <= 1'b0;
         div_q <= pwc_pkg::DIV_OFF;
         limit_q <= pwc_pkg::LIMIT_RST;
         cnt_q <= pwc_pkg::COUNT_RST;
         irq_q <= 1'b0;
         swap_q <= 1'b0;
         pend_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
         src_q <= src_d;
         ie_q <= ie_d;
         div_q <= div_d;
         limit_q <= limit_d;
         cnt_q <= cnt_d;
         irq_q <= irq_d;
         swap_q <= swap_d;
         pend_q <= pend_d;
      end
   end

   // prescaler runs only with nonzero code and no halt
   pwc_prescaler u_pre (
      .clk(clk),
      .reset(reset),
      .tick(tick),
      .clear(restart),
      .run(div_q != pwc_pkg::DIV_OFF && !dbg),
      .div_sel(div_q),
      .src_lo(src_q[0]),
      .pulse(pre_pulse)
   );

   ////////////////////////////////////////////////////////////////
   // Bus answer, one cycle after the request is seen
   always_comb begin
      ack_d = wb_cyc_i && wb_stb_i && !ack_q;
      dat_d = 32'h00000000;
      if (rd_ctrl) begin
         dat_d[7:0] = {flag_q, src_q, ie_q, div_q};
      end else if (rd_count) begin
         dat_d[7:0] = cnt_q;
      end else if (rd_limit) begin
         dat_d[7:0] = limit_q;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ack_q <= 1'b0;
         dat_q <= 32'h00000000;
      end else begin
         ack_q <= ack_d;
         dat_q <= dat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign match_irq = irq_q;

   ////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_flag_w1_clear: assert property (
      wr_ctrl && wdat[7] && !hit |=> !flag_q && !match_irq)
      else $error("flag not cleared by write of one");
   a_flag_w0_keep: assert property (
      wr_ctrl && !wdat[7] && flag_q |=> flag_q)
      else $error("flag lost on write of zero");
   a_flag_on_wrap: assert property (
      pre_pulse && !dbg && !restart && cnt_q == limit_q |=> flag_q && cnt_q == 8'h00)
      else $error("no flag or wrap at limit");
   a_src_chg_clear: assert property (
      src_chg |=> cnt_q == 8'h00 && !pre_pulse)
      else $error("source change did not clear");
   a_div_chg_clear: assert property (
      div_chg |=> cnt_q == 8'h00 && !pre_pulse)
      else $error("divider change did not clear");
   a_irq_follow: assert property (
      match_irq == (flag_q && ie_q))
      else $error("request does not follow flag and enable");
   a_div_off_hold: assert property (
      div_q == 4'h0 && !restart |=> $stable(cnt_q))
      else $error("counter moved with prescaler off");
   a_count_read: assert property (
      rd_count |=> wb_ack_o && wb_dat_o == {24'h000000, $past(cnt_q)})
      else $error("count read mismatch");
   a_limit_write: assert property (
      wr_limit |=> limit_q == $past(wdat) && cnt_q == 8'h00)
      else $error("limit write not applied");
   a_zero_limit: assert property (
      limit_q == 8'h00 && step |=> flag_q)
      else $error("zero limit did not set flag");
   a_count_step: assert property (
      step && cnt_q != limit_q |=> cnt_q == $past(cnt_q) + 8'h01)
      else $error("counter did not step by one");
   a_debug_hold: assert property (
      dbg && !restart |=> $stable(cnt_q))
      else $error("counter moved in debug halt");
   a_ack_one: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");

   // Hazard guards: same-cycle races, swaps, halt entry, idle bus
   a_set_wins: assert property (
      hit |=> flag_q)
      else $error("flag lost to a same-cycle clear");
   a_pulse_needs_div: assert property (
      pre_pulse |-> div_q != pwc_pkg::DIV_OFF)
      else $error("prescaler pulsed with divider off");
   a_count_in_range: assert property (
      limit_q != 8'h00 |-> cnt_q <= limit_q)
      else $error("count beyond the limit");
   a_swap_quiet: assert property (
      src_chg |=> !tick)
      else $error("false source edge after a swap");
   a_halt_keeps_pulse: assert property (
      pre_pulse && dbg && !restart |=> pend_q)
      else $error("pulse lost at debug entry");
   a_irq_needs_flag: assert property (
      match_irq |-> flag_q)
      else $error("request without flag");
   a_dat_idle_zero: assert property (
      !wb_ack_o |-> wb_dat_o == 32'h00000000)
      else $error("read data outside the ack cycle");

   c_flag_set: cover property (hit && limit_q != 8'h00);
   c_irq_rise: cover property (!match_irq ##1 match_irq);
   c_debug_freeze: cover property (dbg && pre_pulse);
   c_set_clear_race: cover property (hit && wr_ctrl && wdat[7]);
   c_halt_pending: cover property (pend_q && !dbg);
endmodule

/* File: design/pwc_pkg.sv */
/*
 Constants of the periodic wakeup counter: register offsets,
 control field positions, reset values and field widths.
 Assumes a byte-addressed Wishbone bus with 32-bit data.
*/
package pwc_pkg;
   localparam int unsigned ADR_W = 4;
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_COUNT = 4'h4;
   localparam logic [3:0] OFS_LIMIT = 4'h8;
   localparam int unsigned FLAG_BIT = 7;
   localparam int unsigned SRC_HI = 6;
   localparam int unsigned SRC_LO = 5;
   localparam int unsigned IE_BIT = 4;
   localparam int unsigned DIV_HI = 3;
   localparam logic [1:0] SRC_RST = 2'h0;
   localparam logic [3:0] DIV_OFF = 4'h0;
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [7:0] LIMIT_RST = 8'h00;
   localparam int unsigned PRE_W = 18;
   localparam logic [PRE_W-1:0] PRE_RST = 18'h00000;
   localparam int unsigned SYNC_W = 4;
   localparam int unsigned DBG_IDX = 3;
endpackage

/* File: design/pwc_prescaler.sv */
/*
 Prescaler of the periodic wakeup counter: counts edges of the
 selected source and gives one pulse per divide-by period.
 Assumes tick is already a one-cycle pulse in the clk domain.
*/
`timescale 1ns/1ps
module pwc_prescaler (
   input wire logic clk,
   input wire logic reset,
   input wire logic tick,
   input wire logic clear,
   input wire logic run,
   input wire logic [3:0] div_sel,
   input wire logic src_lo,
   output logic pulse
);
   logic [pwc_pkg::PRE_W-1:0] cnt_q, cnt_d;
   logic pulse_q, pulse_d;
   logic [pwc_pkg::PRE_W-1:0] div_now;

   ////////////////////////////////////////////////////////////////
   // Divide-by table, indexed by low source bit and divider code
   function automatic logic [pwc_pkg::PRE_W-1:0] divisor(input logic lo, input logic [3:0] s);
      logic [pwc_pkg::PRE_W-1:0] d;
      d = 18'h00001;
      if (!lo) begin
         case (s)
            4'h1: d = 18'h00008;
            4'h2: d = 18'h00020;
            4'h3: d = 18'h00040;
            4'h4: d = 18'h00080;
            4'h5: d = 18'h00100;
            4'h6: d = 18'h00200;
            4'h7: d = 18'h00400;
            4'h9: d = 18'h00002;
            4'hA: d = 18'h00004;
            4'hB: d = 18'h0000A;
            4'hC: d = 18'h00010;
            4'hD: d = 18'h00064;
            4'hE: d = 18'h001F4;
            4'hF: d = 18'h003E8;
            default: d = 18'h00001;
         endcase
      end else begin
         case (s)
            4'h1: d = 18'h00400;
            4'h2: d = 18'h00800;
            4'h3: d = 18'h01000;
            4'h4: d = 18'h02000;
            4'h5: d = 18'h04000;
            4'h6: d = 18'h08000;
            4'h7: d = 18'h10000;
            4'h8: d = 18'h003E8;
            4'h9: d = 18'h007D0;
            4'hA: d = 18'h01388;
            4'hB: d = 18'h02710;
            4'hC: d = 18'h04E20;
            4'hD: d = 18'h0C350;
            4'hE: d = 18'h186A0;
            4'hF: d = 18'h30D40;
            default: d = 18'h00001;
         endcase
      end
      return d;
   endfunction

   assign div_now = divisor(src_lo, div_sel);

   always_comb begin
      cnt_d = cnt_q;
      pulse_d = 1'b0;
      if (clear) begin
         cnt_d = pwc_pkg::PRE_RST;
      end else if (run && tick) begin
         if (cnt_q >= div_now - 18'h00001) begin
            cnt_d = pwc_pkg::PRE_RST;
            pulse_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 18'h00001;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_q <= 18'h00000;
         pulse_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         pulse_q <= pulse_d;
      end
   end

   assign pulse = pulse_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_div_one_pass: assert property (
      run && tick && !clear && div_now == 18'h00001 |=> pulse)
      else $error("divide-by-1 did not pass a source edge");
   a_off_no_pulse: assert property (
      !run |=> !pulse)
      else $error("prescaler pulsed while off");
endmodule

/* File: verification/pwc_tb.sv */
/*
 Self-checking bench for the periodic wakeup counter: Wishbone register
 tasks plus source pin edge stimulus. Assumes pwc_pkg and pwc_counter.
*/
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, halt = 1'b0, irq;
   logic [3:0] adr = 4'h0, sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, ack_dat;
   logic ack;
   logic [2:0] pins = 3'h0;
   int fails = 0;
   int n_checks = 0;
   int srcs [11] = '{0, 0, 0, 0, 0, 0, 0, 0, 2, 1, 3};
   int codes [11] = '{1, 2, 8, 9, 10, 11, 12, 13, 9, 8, 1};
   int divs [11] = '{8, 32, 1, 2, 4, 10, 16, 100, 2, 1000, 1024};

   always #5 clk = ~clk;

   pwc_counter dut_u (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .low_power_osc_clk(pins[0]), .external_ref_clk(pins[1]), .internal_ref_clk(pins[2]),
      .debug_halt(halt), .match_irq(irq));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         fails++;
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Single classic cycle; waits for ack, takes data at that edge
   task automatic wb_cycle(input logic w, input logic [3:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      wdat <= {24'h000000, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) begin
         $display("unexpected at %0t: no ack", $time);
         fails++;
      end
      ack_dat = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      wb_cycle(1'b1, a, d);
   endtask

   task automatic rd_check(input logic [3:0] a, input logic [7:0] exp);
      wb_cycle(1'b0, a, 8'h00);
      check(ack_dat, {24'h000000, exp});
   endtask

   // Rising edges on one source pin, 3 clk per phase, then pipeline settle
   task automatic edges(input int which, input int n);
      repeat (n) begin
         @(posedge clk);
         pins[which] <= 1'b1;
         repeat (3) @(posedge clk);
         pins[which] <= 1'b0;
         repeat (2) @(posedge clk);
      end
      repeat (4) @(posedge clk);
   endtask

   function automatic int pin_of(input int s);
      return (s >= 2) ? 2 : s;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      rd_check(pwc_pkg::OFS_CTRL, 8'h00); // reset control
      rd_check(pwc_pkg::OFS_COUNT, 8'h00); // reset count
      rd_check(pwc_pkg::OFS_LIMIT, 8'h00); // reset limit
      rd_check(4'hC, 8'h00); // unmapped reads zero
      edges(0, 3);
      rd_check(pwc_pkg::OFS_COUNT, 8'h00); // divider off
      // Divide table across sources and codes
      for (int i = 0; i < 11; i++) begin
         wr(pwc_pkg::OFS_LIMIT, 8'hFF);
         wr(pwc_pkg::OFS_CTRL, 8'(srcs[i] * 32 + codes[i]));
         edges(pin_of(srcs[i]), divs[i] - 1);
         rd_check(pwc_pkg::OFS_COUNT, 8'h00); // one edge short
         edges(pin_of(srcs[i]), 1);
         rd_check(pwc_pkg::OFS_COUNT, 8'h01); // one period
      end
      // Unselected pin must not count
      wr(pwc_pkg::OFS_CTRL, 8'h48);
      edges(0, 3);
      edges(1, 2);
      rd_check(pwc_pkg::OFS_COUNT, 8'h00); // wrong source ignored
      // Modulo wrap, flag and interrupt
      wr(pwc_pkg::OFS_CTRL, 8'h18);
      wr(pwc_pkg::OFS_LIMIT, 8'h03);
      edges(0, 3);
      rd_check(pwc_pkg::OFS_COUNT, 8'h03); // counts to limit
      rd_check(pwc_pkg::OFS_CTRL, 8'h18); // no flag yet
      check({31'h0, irq}, 32'h0); // no request yet
      edges(0, 1);
      rd_check(pwc_pkg::OFS_COUNT, 8'h00); // wraps to zero
      rd_check(pwc_pkg::OFS_CTRL, 8'h98); // flag on wrap
      check({31'h0, irq}, 32'h1); // request with enable
      wr(pwc_pkg::OFS_CTRL, 8'h18);
      rd_check(pwc_pkg::OFS_CTRL, 8'h98); // zero leaves flag
      wr(pwc_pkg::OFS_CTRL, 8'h98);
      rd_check(pwc_pkg::OFS_CTRL, 8'h18); // one clears flag
      check({31'h0, irq}, 32'h0); // request withdrawn
      // Limit zero, enable off
      wr(pwc_pkg::OFS_CTRL, 8'h08);
      wr(pwc_pkg::OFS_LIMIT, 8'h00);
      edges(0, 1);
      rd_check(pwc_pkg::OFS_CTRL, 8'h88); // flag every pulse
      check({31'h0, irq}, 32'h0); // polled when disabled
      wr(pwc_pkg::OFS_CTRL, 8'h88);
      // Restarts and read-only count
      wr(pwc_pkg::OFS_LIMIT, 8'hFF);
      edges(0, 2);
      wr(pwc_pkg::OFS_COUNT, 8'h55);
      wr(4'hC, 8'h77);
      rd_check(pwc_pkg::OFS_COUNT, 8'h02); // count write ignored
      rd_check(pwc_pkg::OFS_CTRL, 8'h08); // flag stays clear
      wr(pwc_pkg::OFS_CTRL, 8'h08);
      rd_check(pwc_pkg::OFS_COUNT, 8'h02); // same value no restart
      wr(pwc_pkg::OFS_CTRL, 8'h09);
      rd_check(pwc_pkg::OFS_COUNT, 8'h00); // divider change clears
      edges(0, 3);
      rd_check(pwc_pkg::OFS_COUNT, 8'h01); // divide by 2, prescaler left at 1
      wr(pwc_pkg::OFS_CTRL, 8'h0A);
      rd_check(pwc_pkg::OFS_COUNT, 8'h00); // divider change clears
      edges(0, 3);
      rd_check(pwc_pkg::OFS_COUNT, 8'h00); // prescaler cleared too
      wr(pwc_pkg::OFS_CTRL, 8'h4A);
      rd_check(pwc_pkg::OFS_COUNT, 8'h00); // source change clears
      edges(2, 3);
      rd_check(pwc_pkg::OFS_COUNT, 8'h00); // prescaler cleared too
      edges(2, 1);
      rd_check(pwc_pkg::OFS_COUNT, 8'h01); // internal source counts
      edges(2, 1);
      wr(pwc_pkg::OFS_LIMIT, 8'hFF);
      rd_check(pwc_pkg::OFS_COUNT, 8'h00); // limit write clears
      rd_check(pwc_pkg::OFS_LIMIT, 8'hFF); // limit stored
      edges(2, 3);
      rd_check(pwc_pkg::OFS_COUNT, 8'h00); // prescaler cleared too
      // Debug freeze and resume
      wr(pwc_pkg::OFS_CTRL, 8'h08);
      edges(0, 2);
      halt <= 1'b1;
      repeat (4) @(posedge clk);
      edges(0, 3);
      rd_check(pwc_pkg::OFS_COUNT, 8'h02); // frozen
      halt <= 1'b0;
      repeat (4) @(posedge clk);
      edges(0, 1);
      rd_check(pwc_pkg::OFS_COUNT, 8'h03); // resumes from held value
      // Second reset mid-run
      reset <= 1'b1;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      rd_check(pwc_pkg::OFS_CTRL, 8'h00); // control cleared
      rd_check(pwc_pkg::OFS_COUNT, 8'h00); // count cleared
      rd_check(pwc_pkg::OFS_LIMIT, 8'h00); // limit cleared
      print_verdict();
   end

   // Watchdog at 40k cycles, well beyond the expected run of about 14k
   initial begin
      #400000;
      fails++;
      print_verdict();
   end
endmodule
